/* File: hw/rac_pkg.sv */
// constants shared by the receiver adjust command link
// assumes a single 100 MHz system clock
package rac_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ          = 100_000_000;
  localparam int BAUD_RATE       = 9600;
  localparam int BAUD_DIV        = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam int BOOT_PWR_MS     = 10_000;
  localparam int BOOT_RST_MS     = 400;
  localparam int BOOT_PWR_CYC    = (CLK_HZ / 1000) * BOOT_PWR_MS;
  localparam int BOOT_RST_CYC    = (CLK_HZ / 1000) * BOOT_RST_MS;

  // ---------------------------------------------------------------------------
  // serial frame and commands
  // ---------------------------------------------------------------------------
  localparam int DATA_BITS       = 8;
  localparam logic [7:0] CMD_GAIN     = 8'h01;
  localparam logic [7:0] CMD_PHASE    = 8'h02;
  localparam logic [7:0] CMD_OFFS_A   = 8'h03;
  localparam logic [7:0] CMD_OFFS_B   = 8'h04;
  localparam logic [7:0] CMD_SAVE     = 8'h05;
  localparam logic [7:0] RESP_REJECT  = 8'h3F;

  // ---------------------------------------------------------------------------
  // settings and link selection
  // ---------------------------------------------------------------------------
  localparam int SET_W           = 8;
  localparam logic [SET_W-1:0] SET_RST = 8'h80;
  localparam int NV_W            = 4 * SET_W;
  localparam int NV_GAIN_LSB     = 0;
  localparam int NV_PHASE_LSB    = 8;
  localparam int NV_OFFS_A_LSB   = 16;
  localparam int NV_OFFS_B_LSB   = 24;
  localparam logic JMP_POS_B     = 1'b1;

  typedef enum logic [2:0] {
    RAC_BOOT, RAC_CMD, RAC_ARG, RAC_SAVE, RAC_RESP, RAC_WAIT
  } rac_state_t;

endpackage

/* File: hw/rac_ser_if.sv */
// byte-level carrier between the command core and its serial engine
// assumes both ends run on clk_sys
`timescale 1ns/10ps
`default_nettype none
interface rac_ser_if;
  logic [7:0] rx_byte;
  logic       rx_valid;
  logic [7:0] tx_byte;
  logic       tx_start;
  logic       tx_busy;

  modport core (input rx_byte, input rx_valid, output tx_byte, output tx_start, input tx_busy);
  modport phy  (output rx_byte, output rx_valid, input tx_byte, input tx_start, output tx_busy);
endinterface
`default_nettype wire

/* File: hw/rac_uart.sv */
// asynchronous serial engine: 1 start, 8 data lsb first, no parity, 1 stop
// assumes rx_line is already synchronised to clk_sys
`timescale 1ns/10ps
`default_nettype none
module rac_uart #(
  parameter int DIV = rac_pkg::BAUD_DIV
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // serial lines
  input  wire logic rx_line,
  output logic      tx_line,
  // byte side
  rac_ser_if.phy    ser
);
  import rac_pkg::*;

  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] DIV_M1  = CW'(DIV - 1);
  localparam logic [CW-1:0] HALF_M1 = CW'(DIV / 2 - 1);

  // ---------------------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------------------
  logic          rx_busy_r;
  logic [CW-1:0] rx_cnt_r;
  logic [3:0]    rx_bit_r;
  logic [7:0]    rx_sh_r;
  logic [7:0]    rx_byte_r;
  logic          rx_valid_r;
  wire           rx_tick = (rx_cnt_r == '0);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_busy_r  <= 1'b0;
      rx_cnt_r   <= '0;
      rx_bit_r   <= 4'h0;
      rx_sh_r    <= 8'h00;
      rx_byte_r  <= 8'h00;
      rx_valid_r <= 1'b0;
    end else begin
      rx_valid_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!rx_line) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r  <= HALF_M1;
          rx_bit_r  <= 4'h0;
        end
      end else if (!rx_tick) begin
        rx_cnt_r <= rx_cnt_r - 1'b1;
      end else begin
        rx_cnt_r <= DIV_M1;
        rx_bit_r <= rx_bit_r + 4'h1;
        // a start bit gone high at mid-bit is a glitch, drop it
        if (rx_bit_r == 4'h0 && rx_line) begin
          rx_busy_r <= 1'b0;
        end else if (rx_bit_r == 4'(DATA_BITS + 1)) begin
          rx_busy_r  <= 1'b0;
          rx_byte_r  <= rx_sh_r;
          rx_valid_r <= rx_line;
        end else if (rx_bit_r != 4'h0) begin
          rx_sh_r <= {rx_line, rx_sh_r[7:1]};
        end
      end
    end
  end

  assign ser.rx_byte  = rx_byte_r;
  assign ser.rx_valid = rx_valid_r;

  // ---------------------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------------------
  logic [9:0]    tx_sh_r;
  logic [3:0]    tx_left_r;
  logic [CW-1:0] tx_cnt_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_sh_r   <= 10'h3FF;
      tx_left_r <= 4'h0;
      tx_cnt_r  <= '0;
    end else if (tx_left_r == 4'h0) begin
      if (ser.tx_start) begin
        tx_sh_r   <= {1'b1, ser.tx_byte, 1'b0};
        tx_left_r <= 4'(DATA_BITS + 2);
        tx_cnt_r  <= DIV_M1;
      end
    end else if (tx_cnt_r != '0) begin
      tx_cnt_r <= tx_cnt_r - 1'b1;
    end else begin
      tx_cnt_r  <= DIV_M1;
      tx_sh_r   <= {1'b1, tx_sh_r[9:1]};
      tx_left_r <= tx_left_r - 4'h1;
    end
  end

  assign tx_line     = tx_sh_r[0];
  assign ser.tx_busy = (tx_left_r != 4'h0);

endmodule
`default_nettype wire

/* File: hw/rac_top.sv */
// command interpreter of the receiver adjust link: balance and offset settings,
// save to and restore from nonvolatile storage, boot hold-off and link select
// assumes nv_rd_data is a steady image of the stored word on clk_sys
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - separate gain and phase balance commands
// - save command stores; power-up restores settings
// - one offset command per channel A, B
// - matched jumpers choose RS485 or RS232 input
// - ready within ten seconds after power-up
// - ready 0.4 s after blanking ends
// - ready 0.4 s after wake-up ends
// - 9600 baud, 8N1 on both sides
// - blanking holds controller in reset
// - bytes ignored during boot; host waits
// - transmit driver released after each response
module rac_top #(
  parameter int BAUD_DIV_P = rac_pkg::BAUD_DIV,
  parameter int BOOT_PWR_P = rac_pkg::BOOT_PWR_CYC,
  parameter int BOOT_RST_P = rac_pkg::BOOT_RST_CYC
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  // reset sources, active low pins
  input  wire logic                      acquisition_blank_in_n,
  input  wire logic                      serial_wakeup_reset_in_n,
  // link selection jumpers, high = position B
  input  wire logic                      link_select_jumper_first,
  input  wire logic                      link_select_jumper_second,
  // rs485 pins
  input  wire logic                      rs485_rx,
  output logic                           rs485_tx,
  output logic                           rs485_tx_oe,
  // rs232 pins
  input  wire logic                      rs232_rx,
  output logic                           rs232_tx,
  // nonvolatile storage
  input  wire logic [rac_pkg::NV_W-1:0]  nv_rd_data,
  output logic      [rac_pkg::NV_W-1:0]  nv_wr_data,
  output logic                           nv_wr_en,
  // settings and status
  output logic      [rac_pkg::SET_W-1:0] gain_adj,
  output logic      [rac_pkg::SET_W-1:0] phase_adj,
  output logic      [rac_pkg::SET_W-1:0] offset_a,
  output logic      [rac_pkg::SET_W-1:0] offset_b,
  output logic                           ready
);
  import rac_pkg::*;

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  localparam int NS = 6;
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  wire  [NS-1:0] pins_w = {acquisition_blank_in_n, serial_wakeup_reset_in_n, link_select_jumper_first,
                           link_select_jumper_second, rs485_rx, rs232_rx};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= '1;
      sync2_r <= '1;
    end else begin
      sync1_r <= pins_w;
      sync2_r <= sync1_r;
    end
  end

  wire blank_act_w = ~sync2_r[5];
  wire wake_act_w  = ~sync2_r[4];
  // a mismatched jumper pair is treated as the factory setting
  wire sel232_w    = (sync2_r[3] == JMP_POS_B) && (sync2_r[2] == JMP_POS_B);
  wire rx_line_w   = sel232_w ? sync2_r[0] : sync2_r[1];
  wire hold_w      = blank_act_w | wake_act_w;

  // ---------------------------------------------------------------------------
  // serial engine
  // ---------------------------------------------------------------------------
  rac_ser_if ser ();
  logic tx_line_w;

  rac_uart #(.DIV(BAUD_DIV_P)) u_uart (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .rx_line (rx_line_w),
    .tx_line (tx_line_w),
    .ser     (ser.phy)
  );

  // ---------------------------------------------------------------------------
  // boot hold-off
  // ---------------------------------------------------------------------------
  // counts up to 1e9 cycles; simulations shorten it through the parameters
  localparam int BW = 31;
  localparam logic [BW-1:0] PWR_LIM = BW'(BOOT_PWR_P - 1);
  localparam logic [BW-1:0] RST_LIM = BW'(BOOT_RST_P - 1);

  rac_state_t     st_r;
  rac_state_t     st_nxt;
  logic [BW-1:0]  boot_cnt_r;
  logic [BW-1:0]  boot_lim_r;
  wire            boot_done_w = (st_r == RAC_BOOT) && (boot_cnt_r == boot_lim_r);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      boot_cnt_r <= '0;
      boot_lim_r <= PWR_LIM;
    end else if (hold_w) begin
      boot_cnt_r <= '0;
      boot_lim_r <= RST_LIM;
    end else if (st_r == RAC_BOOT && !boot_done_w) begin
      boot_cnt_r <= boot_cnt_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------------------
  logic [7:0]       cmd_r;
  logic [7:0]       resp_r;
  logic [SET_W-1:0] gain_r;
  logic [SET_W-1:0] phase_r;
  logic [SET_W-1:0] offa_r;
  logic [SET_W-1:0] offb_r;
  logic             nv_wr_r;
  logic             ready_r;

  wire cmd_set_w   = (ser.rx_byte == CMD_GAIN) || (ser.rx_byte == CMD_PHASE)
                  || (ser.rx_byte == CMD_OFFS_A) || (ser.rx_byte == CMD_OFFS_B);
  wire cmd_save_w  = (ser.rx_byte == CMD_SAVE);
  wire byte_in_w   = ser.rx_valid && !hold_w;
  wire [NV_W-1:0] nv_img_w = {offb_r, offa_r, phase_r, gain_r};

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      RAC_BOOT: if (boot_done_w) st_nxt = RAC_CMD;
      RAC_CMD: begin
        if (byte_in_w && cmd_set_w) st_nxt = RAC_ARG;
        else if (byte_in_w)         st_nxt = cmd_save_w ? RAC_SAVE : RAC_RESP;
      end
      RAC_ARG:  if (byte_in_w) st_nxt = RAC_RESP;
      RAC_SAVE: st_nxt = RAC_RESP;
      RAC_RESP: if (!ser.tx_busy) st_nxt = RAC_WAIT;
      RAC_WAIT: if (!ser.tx_busy) st_nxt = RAC_CMD;
      default:  st_nxt = RAC_BOOT;
    endcase
    if (hold_w) st_nxt = RAC_BOOT;
  end

  // ready follows the next state in its own flop, so the pin never glitches on a decode
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r    <= RAC_BOOT;
      ready_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      ready_r <= (st_nxt != RAC_BOOT);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmd_r  <= 8'h00;
      resp_r <= 8'h00;
    end else if (st_r == RAC_CMD && byte_in_w) begin
      cmd_r  <= ser.rx_byte;
      resp_r <= (cmd_set_w || cmd_save_w) ? ser.rx_byte : RESP_REJECT;
    end
  end

  // settings: restored at the end of every boot, then written by commands
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gain_r  <= SET_RST;
      phase_r <= SET_RST;
      offa_r  <= SET_RST;
      offb_r  <= SET_RST;
    end else if (boot_done_w) begin
      gain_r  <= nv_rd_data[NV_GAIN_LSB +: SET_W];
      phase_r <= nv_rd_data[NV_PHASE_LSB +: SET_W];
      offa_r  <= nv_rd_data[NV_OFFS_A_LSB +: SET_W];
      offb_r  <= nv_rd_data[NV_OFFS_B_LSB +: SET_W];
    end else if (st_r == RAC_ARG && byte_in_w) begin
      if (cmd_r == CMD_GAIN)   gain_r  <= ser.rx_byte;
      if (cmd_r == CMD_PHASE)  phase_r <= ser.rx_byte;
      if (cmd_r == CMD_OFFS_A) offa_r  <= ser.rx_byte;
      if (cmd_r == CMD_OFFS_B) offb_r  <= ser.rx_byte;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      nv_wr_r    <= 1'b0;
      nv_wr_data <= '0;
    end else begin
      nv_wr_r <= (st_r == RAC_SAVE);
      if (st_r == RAC_SAVE) nv_wr_data <= nv_img_w;
    end
  end

  // ---------------------------------------------------------------------------
  // response and outputs
  // ---------------------------------------------------------------------------
  assign ser.tx_byte  = resp_r;
  assign ser.tx_start = (st_r == RAC_RESP) && !ser.tx_busy;
  // the rs485 driver floats except during a response frame, so other slaves can talk
  assign rs485_tx     = tx_line_w;
  assign rs485_tx_oe  = ser.tx_busy && !sel232_w;
  assign rs232_tx     = tx_line_w;
  assign nv_wr_en     = nv_wr_r;
  assign gain_adj     = gain_r;
  assign phase_adj    = phase_r;
  assign offset_a     = offa_r;
  assign offset_b     = offb_r;
  assign ready        = ready_r;

endmodule
`default_nettype wire

/* File: verification/rac_chk.sv */
// checker on the top ports of the adjust command link
// assumes a bind into rac_top, one clk_sys domain
`timescale 1ns/10ps
`default_nettype none
module rac_chk #(
  parameter int BAUD_DIV_P = rac_pkg::BAUD_DIV,
  parameter int BOOT_PWR_P = rac_pkg::BOOT_PWR_CYC,
  parameter int BOOT_RST_P = rac_pkg::BOOT_RST_CYC
) (
  // clock, reset, hold and jumper inputs
  input wire logic                      clk_sys,
  input wire logic                      arst_n,
  input wire logic                      acquisition_blank_in_n,
  input wire logic                      serial_wakeup_reset_in_n,
  input wire logic                      link_select_jumper_first,
  input wire logic                      link_select_jumper_second,
  // watched outputs
  input wire logic                      rs485_tx,
  input wire logic                      rs485_tx_oe,
  input wire logic [rac_pkg::NV_W-1:0]  nv_wr_data,
  input wire logic                      nv_wr_en,
  input wire logic [rac_pkg::SET_W-1:0] gain_adj,
  input wire logic [rac_pkg::SET_W-1:0] phase_adj,
  input wire logic [rac_pkg::SET_W-1:0] offset_a,
  input wire logic [rac_pkg::SET_W-1:0] offset_b,
  input wire logic                      ready
);
  import rac_pkg::*;
  logic [31:0] wait_r;
  logic [31:0] oe_run_r;
  logic        pwr_r;
  wire         held    = !acquisition_blank_in_n || !serial_wakeup_reset_in_n;
  wire         sel_232 = link_select_jumper_first && link_select_jumper_second;
  // wait count restarts at every hold, so one counter serves both boot kinds
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wait_r   <= '0;
      oe_run_r <= '0;
      pwr_r    <= 1'b1;
    end else begin
      wait_r   <= (ready || held) ? '0 : wait_r + 1;
      oe_run_r <= rs485_tx_oe ? oe_run_r + 1 : '0;
      pwr_r    <= pwr_r && !ready && !held;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_blank; !acquisition_blank_in_n [*5]; endsequence
  sequence s_wake; !serial_wakeup_reset_in_n [*5]; endsequence
  property p_blank; s_blank |-> !ready; endproperty
  property p_wake; s_wake |-> !ready; endproperty
  property p_pwr_wait; $rose(ready) && pwr_r |-> wait_r >= BOOT_PWR_P - 2; endproperty
  property p_rst_wait; $rose(ready) |-> wait_r >= BOOT_RST_P - 2; endproperty
  property p_wait_max; wait_r <= (pwr_r ? BOOT_PWR_P : BOOT_RST_P) + 6; endproperty
  property p_oe_sel; rs485_tx_oe |-> !sel_232; endproperty
  property p_start; $rose(rs485_tx_oe) |-> !rs485_tx; endproperty
  property p_idle; !rs485_tx_oe && !sel_232 |-> rs485_tx; endproperty
  property p_oe_len; oe_run_r <= 10 * BAUD_DIV_P + 2; endproperty
  property p_oe_fell; $fell(rs485_tx_oe) |-> oe_run_r >= 10 * BAUD_DIV_P - 2; endproperty
  property p_nv_pulse; nv_wr_en |=> !nv_wr_en; endproperty
  property p_nv_data; nv_wr_en |-> nv_wr_data == {offset_b, offset_a, phase_adj, gain_adj}; endproperty
  a_blank: assert property (p_blank) else $error("ready high during blanking");
  a_wake: assert property (p_wake) else $error("ready high during wake-up hold");
  a_pwr_wait: assert property (p_pwr_wait) else $error("power-up boot too short");
  a_rst_wait: assert property (p_rst_wait) else $error("hold boot too short");
  a_wait_max: assert property (p_wait_max) else $error("boot too long");
  a_oe_sel: assert property (p_oe_sel) else $error("rs485 driver on with rs232 chosen");
  a_start: assert property (p_start) else $error("frame without start bit");
  a_idle: assert property (p_idle) else $error("line not idle with driver off");
  a_oe_len: assert property (p_oe_len) else $error("driver held past frame");
  a_oe_fell: assert property (p_oe_fell) else $error("frame cut short");
  a_nv_pulse: assert property (p_nv_pulse) else $error("store strobe longer than one cycle");
  a_nv_data: assert property (p_nv_data) else $error("stored word differs from settings");
endmodule
bind rac_top rac_chk #(.BAUD_DIV_P(BAUD_DIV_P), .BOOT_PWR_P(BOOT_PWR_P), .BOOT_RST_P(BOOT_RST_P)) u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .acquisition_blank_in_n(acquisition_blank_in_n),
  .serial_wakeup_reset_in_n(serial_wakeup_reset_in_n), .link_select_jumper_first(link_select_jumper_first),
  .link_select_jumper_second(link_select_jumper_second), .rs485_tx(rs485_tx), .rs485_tx_oe(rs485_tx_oe),
  .nv_wr_data(nv_wr_data), .nv_wr_en(nv_wr_en), .gain_adj(gain_adj), .phase_adj(phase_adj),
  .offset_a(offset_a), .offset_b(offset_b), .ready(ready));
`default_nettype wire

/* File: verification/rac_host.sv */
// host master model for the serial command link
// assumes tasks are called from the bench at a falling clock edge
`timescale 1ns/10ps
`default_nettype none
module rac_host #(
  parameter int DIV = 16
) (
  input  wire logic clk_sys,
  input  wire logic sel_232,
  output logic      line_485,
  output logic      line_232,
  input  wire logic dev_485,
  input  wire logic dev_oe,
  input  wire logic dev_232
);
  logic tx_r = 1'b1;
  // a released pair is pulled to idle by the failsafe bias
  wire  bus_485 = dev_oe ? dev_485 : 1'b1;
  wire  rx = sel_232 ? dev_232 : bus_485;
  assign line_485 = sel_232 ? 1'b1 : tx_r;
  assign line_232 = sel_232 ? tx_r : 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys);
      tx_r = f[i];
      repeat (DIV - 1) @(negedge clk_sys);
    end
  endtask
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (rx === 1'b1 && n < 60 * DIV) begin
      @(negedge clk_sys);
      n++;
    end
    if (rx !== 1'b0)
      return;
    repeat (DIV / 2) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(negedge clk_sys);
      b[i] = rx;
    end
    repeat (DIV) @(negedge clk_sys);
    ok = (rx === 1'b1);
  endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the adjust command link
// assumes rac_host as the far side and rac_chk bound to the top
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import rac_pkg::*;
  localparam int DIV = 16;
  localparam int BOOT_PWR = 200;
  localparam int BOOT_RST = 50;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        blank_n = 1'b1;
  logic        wake_n = 1'b1;
  logic        jmp = 1'b0;
  logic        jmp_b = 1'b0;
  logic [31:0] nv_img = 32'h44332211;
  logic [31:0] exp_set;
  logic [31:0] nv_wd;
  logic [7:0]  gain, phase, offa, offb;
  logic        rx485, rx232, tx485, oe485, tx232, nv_en, rdy;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;
  always #5 clk_sys = ~clk_sys;
  // stands in for the nonvolatile part
  always @(posedge clk_sys) if (nv_en === 1'b1) nv_img <= nv_wd;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  rac_host #(.DIV(DIV)) u_host (.clk_sys(clk_sys), .sel_232(jmp && jmp_b), .line_485(rx485), .line_232(rx232),
    .dev_485(tx485), .dev_oe(oe485), .dev_232(tx232));
  rac_top #(.BAUD_DIV_P(DIV), .BOOT_PWR_P(BOOT_PWR), .BOOT_RST_P(BOOT_RST)) u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .acquisition_blank_in_n(blank_n), .serial_wakeup_reset_in_n(wake_n),
    .link_select_jumper_first(jmp), .link_select_jumper_second(jmp_b), .rs485_rx(rx485), .rs485_tx(tx485),
    .rs485_tx_oe(oe485), .rs232_rx(rx232), .rs232_tx(tx232), .nv_rd_data(nv_img), .nv_wr_data(nv_wd),
    .nv_wr_en(nv_en), .gain_adj(gain), .phase_adj(phase), .offset_a(offa), .offset_b(offb), .ready(rdy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_set(input logic [31:0] e);
    chk({offb, offa, phase, gain}, e);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] v, input logic arg, output logic [7:0] r,
                     output logic ok);
    fork
      begin
        u_host.send_byte(c);
        if (arg)
          u_host.send_byte(v);
      end
      u_host.recv_byte(r, ok);
    join
  endtask
  task automatic wait_ready(output int n);
    n = 0;
    while (rdy !== 1'b1 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic t_powerup();
    int n;
    repeat (20) @(negedge clk_sys);
    arst_n = 1'b1;
    wait_ready(n);
    chk(32'(n >= BOOT_PWR - 2 && n <= BOOT_PWR + 4), 32'h1);
    exp_set = nv_img;
    chk_set(exp_set);
  endtask
  task automatic t_set();
    logic [7:0] codes [4] = '{CMD_GAIN, CMD_PHASE, CMD_OFFS_A, CMD_OFFS_B};
    logic [7:0] r;
    logic       ok;
    for (int i = 0; i < 4; i++) begin
      exp_set[i*8 +: 8] = 8'hA1 + 8'(i * 8'h13);
      cmd(codes[i], exp_set[i*8 +: 8], 1'b1, r, ok);
      chk(32'(r), 32'(codes[i]));
      chk(32'(ok), 32'h1);
      chk_set(exp_set);
      repeat (DIV) @(negedge clk_sys);
      chk({oe485, tx485}, 32'h1);
    end
  endtask
  task automatic t_reject();
    logic [7:0] r;
    logic       ok;
    cmd(8'h7E, 8'h00, 1'b0, r, ok);
    chk(32'(r), 32'(RESP_REJECT));
    chk(32'(ok), 32'h1);
    exp_set[7:0] = 8'h5A;
    cmd(CMD_GAIN, 8'h5A, 1'b1, r, ok);
    chk_set(exp_set);
  endtask
  task automatic t_save();
    logic [7:0] r;
    logic       ok;
    cmd(CMD_SAVE, 8'h00, 1'b0, r, ok);
    chk(32'(r), 32'(CMD_SAVE));
    chk(nv_img, exp_set);
  endtask
  task automatic t_hold(input logic wake);
    logic [7:0] r;
    logic       ok;
    int         n;
    cmd(CMD_GAIN, 8'h99, 1'b1, r, ok);
    if (wake)
      wake_n = 1'b0;
    else
      blank_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    chk(32'(rdy), 32'h0);
    cmd(CMD_OFFS_A, 8'h12, 1'b1, r, ok);
    chk(32'(ok), 32'h0);
    wake_n = 1'b1;
    blank_n = 1'b1;
    wait_ready(n);
    chk(32'(n >= BOOT_RST && n <= BOOT_RST + 5), 32'h1);
    chk_set(nv_img);
    exp_set = nv_img;
  endtask
  task automatic t_rs232();
    logic [7:0] r;
    logic       ok;
    // one jumper moved alone keeps the factory rs485 link
    jmp = 1'b1;
    repeat (4) @(negedge clk_sys);
    exp_set[15:8] = 8'h3C;
    cmd(CMD_PHASE, 8'h3C, 1'b1, r, ok);
    chk(32'(ok), 32'h1);
    chk_set(exp_set);
    // let the response frame end before the link changes under it
    repeat (DIV) @(negedge clk_sys);
    jmp_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    exp_set[15:8] = 8'h3D;
    cmd(CMD_PHASE, 8'h3D, 1'b1, r, ok);
    chk(32'(r), 32'(CMD_PHASE));
    chk_set(exp_set);
    repeat (DIV) @(negedge clk_sys);
    jmp = 1'b0;
    jmp_b = 1'b0;
  endtask
  task automatic stop_test();
    $display("TB: compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    t_powerup();
    t_set();
    t_reject();
    t_save();
    t_hold(1'b0);
    t_hold(1'b1);
    t_rs232();
    stop_test();
  end
endmodule
`default_nettype wire
